/* ext_irq_pkg.sv */
// constants, field layout and trigger encodings for the external interrupt conditioner
// assumes the block clock is the high-frequency clock itself
`default_nettype none
package ext_irq_pkg;

   // ***************************************************
   // clocking
   // ***************************************************
   localparam int HIGH_FREQ_CLOCK_HZ = 10_000_000;
   localparam int CLK_SYS_HZ = 10_000_000;
   localparam int CNT_W = 8;
   localparam int NUM_CH = 5;

   // ***************************************************
   // filter times, in periods of the high-frequency clock
   // ***************************************************
   localparam int ZERO_REJECT_HFC = 2;
   localparam int ZERO_ACCEPT_HFC = 6;
   localparam int ONE_SHORT_REJECT_HFC = 15;
   localparam int ONE_SHORT_ACCEPT_HFC = 48;
   localparam int ONE_LONG_REJECT_HFC = 63;
   localparam int ONE_LONG_ACCEPT_HFC = 192;
   localparam int TWO_REJECT_HFC = 7;
   localparam int TWO_ACCEPT_HFC = 24;
   localparam int ONE_SHORT_EST_HFC = 49;
   localparam int ONE_LONG_EST_HFC = 193;
   localparam int TWO_EST_HFC = 25;
   localparam int NT_SWITCH_HFC = 26;

   // threshold sits midway between reject and accept, as a least time (round up)
   localparam logic [CNT_W-1:0] THR_ZERO = CNT_W'(((ZERO_REJECT_HFC + ZERO_ACCEPT_HFC) / 2 * CLK_SYS_HZ
      + HIGH_FREQ_CLOCK_HZ - 1) / HIGH_FREQ_CLOCK_HZ);
   localparam logic [CNT_W-1:0] THR_ONE_SHORT = CNT_W'(((ONE_SHORT_REJECT_HFC + ONE_SHORT_ACCEPT_HFC) / 2
      * CLK_SYS_HZ + HIGH_FREQ_CLOCK_HZ - 1) / HIGH_FREQ_CLOCK_HZ);
   localparam logic [CNT_W-1:0] THR_ONE_LONG = CNT_W'(((ONE_LONG_REJECT_HFC + ONE_LONG_ACCEPT_HFC) / 2
      * CLK_SYS_HZ + HIGH_FREQ_CLOCK_HZ - 1) / HIGH_FREQ_CLOCK_HZ);
   localparam logic [CNT_W-1:0] THR_TWO = CNT_W'(((TWO_REJECT_HFC + TWO_ACCEPT_HFC) / 2 * CLK_SYS_HZ
      + HIGH_FREQ_CLOCK_HZ - 1) / HIGH_FREQ_CLOCK_HZ);
   // longest times round down
   localparam int EST_ONE_SHORT_CYC = ONE_SHORT_EST_HFC * CLK_SYS_HZ / HIGH_FREQ_CLOCK_HZ;
   localparam int EST_ONE_LONG_CYC = ONE_LONG_EST_HFC * CLK_SYS_HZ / HIGH_FREQ_CLOCK_HZ;
   localparam int EST_TWO_CYC = TWO_EST_HFC * CLK_SYS_HZ / HIGH_FREQ_CLOCK_HZ;
   localparam int NT_SWITCH_CYC = NT_SWITCH_HFC * CLK_SYS_HZ / HIGH_FREQ_CLOCK_HZ;
   // samples taken after reset release before the filter adopts the pin level
   localparam logic [1:0] PRIME_CYC = 2'h2;

   // ***************************************************
   // register map and fields
   // ***************************************************
   localparam int SFR_ADDR_W = 6;
   localparam logic [SFR_ADDR_W-1:0] EXT_IRQ_CONTROL_ADDR = 6'h37;
   localparam logic [7:0] EXT_IRQ_CONTROL_RESET = 8'h00;
   localparam logic [7:0] EXT_IRQ_CONTROL_MASK = 8'hf6;
   localparam int BIT_ONE_NOISE = 7;
   localparam int BIT_ZERO_EN = 6;
   localparam int TRIG_FOUR_MSB = 5;
   localparam int TRIG_FOUR_LSB = 4;
   localparam int BIT_TWO_ES = 2;
   localparam int BIT_ONE_ES = 1;

   // channel slots in the latch vector
   localparam int CH_ZERO = 0;
   localparam int CH_ONE = 1;
   localparam int CH_TWO = 2;
   localparam int CH_FOUR = 3;
   localparam int CH_FIVE = 4;

   typedef enum logic [1:0] {
      TRIG_RISE = 2'h0,
      TRIG_FALL = 2'h1,
      TRIG_BOTH = 2'h2,
      TRIG_HIGH = 2'h3
   } trig_e;

endpackage
`default_nettype wire

/* chan_if.sv */
// one conditioning channel: filter output, trigger mode and detected hit
// assumes all members are driven on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
   import ext_irq_pkg::*;
   logic [CNT_W-1:0] thr;
   logic level;
   logic valid;
   trig_e mode;
   logic hit;
   logic armed;
   modport filt (input thr, output level, output valid);
   modport det (input level, input valid, input mode, output hit, output armed);
   modport ctl (output thr, output mode, input level, input valid, input hit, input armed);
endinterface
`default_nettype wire

/* noise_filter.sv */
// pin synchroniser and consecutive-sample noise filter for one channel
// assumes pin_i is asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module noise_filter #(
   parameter int CW = ext_irq_pkg::CNT_W
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // pin and channel
   input wire logic pin_i,
   chan_if.filt ch
);
   import ext_irq_pkg::*;

   logic meta_q, sync_q;
   logic filt_q, filt_d;
   logic valid_q, valid_d;
   logic [1:0] prime_q, prime_d;
   logic [CW-1:0] cnt_q, cnt_d;

   // ***************************************************
   // filter
   // ***************************************************
   always_comb begin
      filt_d = filt_q;
      valid_d = valid_q;
      prime_d = prime_q;
      cnt_d = '0;
      if (!valid_q) begin
         // adopt the settled level so a pin held high at release is no edge
         if (prime_q == PRIME_CYC) begin
            filt_d = sync_q;
            valid_d = 1'b1;
         end else begin
            prime_d = prime_q + 2'h1;
         end
      end else if (sync_q != filt_q) begin
         if ((cnt_q + CW'(1)) >= CW'(ch.thr)) begin
            filt_d = sync_q;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         filt_q <= 1'b0;
         valid_q <= 1'b0;
         prime_q <= 2'h0;
         cnt_q <= '0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         filt_q <= filt_d;
         valid_q <= valid_d;
         prime_q <= prime_d;
         cnt_q <= cnt_d;
      end
   end

   assign ch.level = filt_q;
   assign ch.valid = valid_q;
endmodule
`default_nettype wire

/* trigger_detect.sv */
// edge or level detection on a filtered channel level
// assumes level and mode come from logic on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module trigger_detect (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // channel
   chan_if.det ch
);
   import ext_irq_pkg::*;

   logic prev_q;
   logic seen_q;
   logic armed_q, armed_d;
   logic rise, fall, hit;

   // ***************************************************
   // detection
   // ***************************************************
   always_comb begin
      rise = seen_q && ch.valid && !prev_q && ch.level;
      fall = seen_q && ch.valid && prev_q && !ch.level;
      // level mode armed by a rise
      armed_d = armed_q || rise;
      case (ch.mode)
         TRIG_RISE: hit = rise;
         TRIG_FALL: hit = fall;
         TRIG_BOTH: hit = rise || fall;
         TRIG_HIGH: hit = ch.level && armed_d;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         prev_q <= 1'b0;
         seen_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         prev_q <= ch.level;
         seen_q <= ch.valid;
         armed_q <= armed_d;
      end
   end

   assign ch.hit = hit;
   assign ch.armed = armed_q;
endmodule
`default_nettype wire

/* external_interrupt_conditioner.sv */
// top of the external interrupt conditioner: control register, five channels, request latches
// assumes sfr strobes and latch clears come from the cpu on clk_sys_i; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_conditioner (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // external request pins
   input wire logic ext_request_zero_i,
   input wire logic ext_request_one_i,
   input wire logic ext_request_two_i,
   input wire logic ext_request_four_i,
   input wire logic ext_request_five_i,
   // special function register port
   input wire logic [ext_irq_pkg::SFR_ADDR_W-1:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   // request latches toward the cpu interrupt logic
   input wire logic [ext_irq_pkg::NUM_CH-1:0] latch_clr_i,
   output logic [ext_irq_pkg::NUM_CH-1:0] request_latch_o,
   // shared pin function toward the port logic
   output logic zero_pin_irq_mode_o
);
   import ext_irq_pkg::*;

   localparam int NT_LIM = NT_SWITCH_CYC;

   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] rdata_q, rdata_d;
   logic [NUM_CH-1:0] latch_q, latch_d;
   logic [NUM_CH-1:0] hit_vec, set_vec;
   logic [NUM_CH-1:0] pin_vec;
   logic ctrl_hit;

   chan_if ch [NUM_CH] ();

   assign pin_vec = {ext_request_five_i, ext_request_four_i, ext_request_two_i,
                     ext_request_one_i, ext_request_zero_i};

   // ***************************************************
   // channels
   // ***************************************************
   // fixed falling edge, short filter
   assign ch[CH_ZERO].thr = THR_ZERO;
   assign ch[CH_ZERO].mode = TRIG_FALL;
   assign ch[CH_FIVE].thr = THR_ZERO;
   assign ch[CH_FIVE].mode = TRIG_FALL;
   // filter length follows the noise-time bit
   // bit clear means the long filter
   // threshold switches on the cycle after the write
   assign ch[CH_ONE].thr = ctrl_q[BIT_ONE_NOISE] ? THR_ONE_SHORT : THR_ONE_LONG;
   assign ch[CH_ONE].mode = ctrl_q[BIT_ONE_ES] ? TRIG_FALL : TRIG_RISE;
   assign ch[CH_TWO].mode = ctrl_q[BIT_TWO_ES] ? TRIG_FALL : TRIG_RISE;
   // medium filter on two and four
   assign ch[CH_TWO].thr = THR_TWO;
   assign ch[CH_FOUR].thr = THR_TWO;
   assign ch[CH_FOUR].mode = trig_e'(ctrl_q[TRIG_FOUR_MSB:TRIG_FOUR_LSB]);

   // one filter and detector per input
   for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_chan
      noise_filter u_filt (
         .clk_sys_i(clk_sys_i),
         .rstn_i(rstn_i),
         .pin_i(pin_vec[gi]),
         .ch(ch[gi])
      );
      trigger_detect u_det (
         .clk_sys_i(clk_sys_i),
         .rstn_i(rstn_i),
         .ch(ch[gi])
      );
      assign hit_vec[gi] = ch[gi].hit;
   end

   // ***************************************************
   // control register
   // ***************************************************
   always_comb begin
      ctrl_hit = (sfr_addr_i == EXT_IRQ_CONTROL_ADDR);
      ctrl_d = ctrl_q;
      rdata_d = 8'h00;
      // pin function bit stored with the rest
      if (sfr_wr_i && ctrl_hit) begin
         ctrl_d = sfr_wdata_i & EXT_IRQ_CONTROL_MASK;
      end
      if (sfr_rd_i && ctrl_hit) begin
         rdata_d = ctrl_q & EXT_IRQ_CONTROL_MASK;
      end
   end

   // ***************************************************
   // request latches
   // ***************************************************
   always_comb begin
      set_vec = hit_vec;
      // no latch zero without the pin function
      set_vec[CH_ZERO] = hit_vec[CH_ZERO] && ctrl_q[BIT_ZERO_EN];
      // pin toggles pass as real edges; the enable flag is software's to drop
      // set beats a clear in the same cycle
      latch_d = (latch_q & ~latch_clr_i) | set_vec;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ctrl_q <= EXT_IRQ_CONTROL_RESET;
         rdata_q <= 8'h00;
         latch_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         latch_q <= latch_d;
      end
   end

   assign sfr_rdata_o = rdata_q;
   assign request_latch_o = latch_q;
   assign zero_pin_irq_mode_o = ctrl_q[BIT_ZERO_EN];

   // ***************************************************
   // checks
   // ***************************************************
   // helper: cycles an input has differed from its filtered level
   logic [7:0] est_one_q, est_one_d, est_two_q, est_two_d;

   always_comb begin
      est_one_d = 8'h00;
      est_two_d = 8'h00;
      if (ch[CH_ONE].valid && (pin_vec[CH_ONE] != ch[CH_ONE].level) && !(sfr_wr_i && ctrl_hit)) begin
         est_one_d = (est_one_q == 8'hff) ? est_one_q : est_one_q + 8'h01;
      end
      if (ch[CH_TWO].valid && (pin_vec[CH_TWO] != ch[CH_TWO].level)) begin
         est_two_d = (est_two_q == 8'hff) ? est_two_q : est_two_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         est_one_q <= 8'h00;
         est_two_q <= 8'h00;
      end else begin
         est_one_q <= est_one_d;
         est_two_q <= est_two_d;
      end
   end

   // helper: filtered rise on four since reset, kept apart from the detector's arming
   logic four_lvl_q, four_vld_q, four_seen_q, four_seen_d;

   always_comb begin
      four_seen_d = four_seen_q;
      if (four_vld_q && !four_lvl_q && ch[CH_FOUR].level) begin
         four_seen_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         four_lvl_q <= 1'b0;
         four_vld_q <= 1'b0;
         four_seen_q <= 1'b0;
      end else begin
         four_lvl_q <= ch[CH_FOUR].level;
         four_vld_q <= ch[CH_FOUR].valid;
         four_seen_q <= four_seen_d;
      end
   end

   sequence s_five_low4;
      !$past(ext_request_five_i, 3) && !$past(ext_request_five_i, 4) &&
      !$past(ext_request_five_i, 5) && !$past(ext_request_five_i, 6);
   endsequence

   sequence s_zero_held4;
      $past(ext_request_zero_i, 3) && $past(ext_request_zero_i, 4) &&
      $past(ext_request_zero_i, 5) && $past(ext_request_zero_i, 6);
   endsequence

   sequence s_nt_written;
      $changed(ctrl_q[BIT_ONE_NOISE]);
   endsequence

   a_latch_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (set_vec & latch_clr_i) != '0 |=> (request_latch_o & $past(set_vec & latch_clr_i)) == $past(set_vec & latch_clr_i))
      else $error("a latch lost a set that met a clear");

   // short pulses never pass the filter
   a_zero_filter_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(ch[CH_ZERO].level) && $past(ch[CH_ZERO].valid) |-> s_zero_held4)
      else $error("input zero filter passed a pulse shorter than its threshold");

   a_zero_gate_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !ctrl_q[BIT_ZERO_EN] && !request_latch_o[CH_ZERO] |=> !request_latch_o[CH_ZERO])
      else $error("latch zero set while pin function disabled");

   // high level mode only fires on high level
   a_four_high_lvl: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ch[CH_FOUR].mode == TRIG_HIGH && ch[CH_FOUR].hit |-> ch[CH_FOUR].level ##1 request_latch_o[CH_FOUR])
      else $error("input four level request without high level or latch");

   // falling select fires only on falls
   a_one_fall_edge: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ch[CH_ONE].mode == TRIG_FALL && ch[CH_ONE].hit |-> $fell(ch[CH_ONE].level))
      else $error("input one falling mode fired without a fall");

   a_one_settle_max: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      est_one_q < 8'((ctrl_q[BIT_ONE_NOISE] ? EST_ONE_SHORT_CYC : EST_ONE_LONG_CYC) - 1))
      else $error("input one level not established in time");

   a_two_settle_max: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      est_two_q < 8'(EST_TWO_CYC - 1))
      else $error("input two level not established in time");

   // filter length follows the noise-time bit
   a_nt_switch_time: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      s_nt_written |-> ##[0:NT_LIM] (ch[CH_ONE].thr == (ctrl_q[BIT_ONE_NOISE] ? THR_ONE_SHORT : THR_ONE_LONG)))
      else $error("input one filter length did not follow the write");

   // no level request before a rise
   a_four_need_rise: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !ch[CH_FOUR].armed && !$rose(ch[CH_FOUR].level) |-> !ch[CH_FOUR].hit || ch[CH_FOUR].mode != TRIG_HIGH)
      else $error("input four level request before any rising edge");

   // port function and clear latches after reset
   a_reset_port_in: assert property (@(posedge clk_sys_i)
      !rstn_i |=> !zero_pin_irq_mode_o && request_latch_o == '0)
      else $error("shared zero pin not a port after reset");

   // readback shows the stored bits, reserved bits zero
   a_ctrl_readback: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      sfr_rd_i && ctrl_hit |=> sfr_rdata_o == ($past(ctrl_q) & EXT_IRQ_CONTROL_MASK) && !sfr_rdata_o[0])
      else $error("control register readback wrong");

   // no level request before a rise since reset
   a_four_seen_rise: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ch[CH_FOUR].mode == TRIG_HIGH && !four_seen_d |-> !ch[CH_FOUR].hit)
      else $error("input four level request before a rise");

   // enabled zero fall reaches its latch
   a_zero_fall_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $fell(ch[CH_ZERO].level) && ctrl_q[BIT_ZERO_EN] |=> request_latch_o[CH_ZERO])
      else $error("input zero fall did not set its latch");

   // input five falls set its latch
   a_five_fall_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $fell(ch[CH_FIVE].level) |=> request_latch_o[CH_FIVE])
      else $error("input five fall did not set its latch");

   // input five filter needs four low samples
   a_five_filter_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $fell(ch[CH_FIVE].level) |-> s_five_low4)
      else $error("input five filter passed a pulse shorter than its threshold");

   // input two fires on its selected edge only
   a_two_edge_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ch[CH_TWO].hit |-> (ctrl_q[BIT_TWO_ES] ? $fell(ch[CH_TWO].level) : $rose(ch[CH_TWO].level)))
      else $error("input two fired on the wrong edge");

   // both-edge mode fires only on a change
   a_four_both_edge: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ch[CH_FOUR].mode == TRIG_BOTH && ch[CH_FOUR].hit |-> $changed(ch[CH_FOUR].level))
      else $error("input four both-edge request without a change");

   a_latch_holds: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (request_latch_o & ~latch_clr_i) != '0 |=> ($past(request_latch_o & ~latch_clr_i) & ~request_latch_o) == '0)
      else $error("a request latch dropped without a clear");

   // pin function follows the written bit
   a_pin_mode_copy: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      sfr_wr_i && ctrl_hit |=> zero_pin_irq_mode_o == $past(sfr_wdata_i[BIT_ZERO_EN]))
      else $error("shared pin function did not follow the write");

   // written noise-time bit picks the filter length
   a_nt_from_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      sfr_wr_i && ctrl_hit |=> ch[CH_ONE].thr == ($past(sfr_wdata_i[BIT_ONE_NOISE]) ? THR_ONE_SHORT : THR_ONE_LONG))
      else $error("input one filter length does not match the write");
endmodule
`default_nettype wire

/* ext_pin_src.sv */
// pin source model: drives the five external request pins like off-chip sources
// assumes the bench calls its tasks just after a falling edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module ext_pin_src (
   // clock
   input wire logic clk_i,
   // pins, in latch-vector slot order
   output var logic [4:0] pins_o
);
   // ***************************************************
   // pin drive
   // ***************************************************
   // four starts high so the bench sees it high across reset release
   initial begin
      pins_o = 5'h19;
   end

   task automatic set_pin(input int ch, input logic lvl);
      pins_o[ch] = lvl;
   endtask

   // pulse of len clock periods, then back to the opposite level
   task automatic pulse(input int ch, input logic lvl, input int len);
      pins_o[ch] = lvl;
      repeat (len) @(negedge clk_i);
      pins_o[ch] = ~lvl;
   endtask
endmodule
`default_nettype wire

/* external_interrupt_conditioner_tb_top.sv */
// self-checking bench for the external interrupt conditioner
// assumes the package, channel interface, design and pin model compile first
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_conditioner_tb_top;
   import ext_irq_pkg::*;
   typedef struct {int ch; logic [7:0] ctl; int rej; int acc; logic hit; logic quick;} row_s;
   logic clk_sys_i;
   logic rstn_i;
   logic [4:0] pins;
   logic [SFR_ADDR_W-1:0] sfr_addr_i;
   logic sfr_wr_i;
   logic [7:0] sfr_wdata_i;
   logic sfr_rd_i;
   logic [7:0] sfr_rdata_o;
   logic [NUM_CH-1:0] latch_clr_i;
   logic [NUM_CH-1:0] request_latch_o;
   logic zero_pin_irq_mode_o;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [7:0] rd;
   logic [7:0] wd;
   row_s rows[7];

   external_interrupt_conditioner dut (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .ext_request_zero_i(pins[CH_ZERO]),
      .ext_request_one_i(pins[CH_ONE]),
      .ext_request_two_i(pins[CH_TWO]),
      .ext_request_four_i(pins[CH_FOUR]),
      .ext_request_five_i(pins[CH_FIVE]),
      .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i),
      .sfr_wdata_i(sfr_wdata_i),
      .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o),
      .latch_clr_i(latch_clr_i),
      .request_latch_o(request_latch_o),
      .zero_pin_irq_mode_o(zero_pin_irq_mode_o)
   );

   ext_pin_src src (
      .clk_i(clk_sys_i),
      .pins_o(pins)
   );

   // ***************************************************
   // clock and hang guard
   // ***************************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // run needs about 15k cycles; over twice that means a hang
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         $display("mismatch timeout expected finish seen hang");
         test_done();
      end
   end

   // ***************************************************
   // helpers
   // ***************************************************
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic sfr_write(input logic [SFR_ADDR_W-1:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge clk_sys_i);
      sfr_wr_i = 1'b0;
   endtask

   task automatic sfr_read(input logic [SFR_ADDR_W-1:0] a, output logic [7:0] d);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge clk_sys_i);
      sfr_rd_i = 1'b0;
      d = sfr_rdata_o;
   endtask

   task automatic clr(input int ch, input logic exp);
      latch_clr_i[ch] = 1'b1;
      @(negedge clk_sys_i);
      latch_clr_i = '0;
      check("latch after clear", {7'h00, exp}, {7'h00, request_latch_o[ch]});
   endtask

   // new control value, then drop whatever the rewrite may have latched
   task automatic ctl(input logic [7:0] d);
      sfr_write(EXT_IRQ_CONTROL_ADDR, d);
      latch_clr_i = '1;
      @(negedge clk_sys_i);
      latch_clr_i = '0;
   endtask

   // bound 0 means no delay limit is checked
   task automatic watch(input int ch, input logic exp, input int bound);
      int first;
      first = 0;
      for (int i = 1; i <= 400; i++) begin
         @(negedge clk_sys_i);
         if (first == 0 && request_latch_o[ch] === 1'b1) first = i;
      end
      check("request latch", {7'h00, exp}, {7'h00, first != 0});
      if (bound > 0 && exp) check("latch delay", 8'h01, {7'h00, first <= bound});
   endtask

   task automatic step(input int ch, input logic lvl, input logic exp, input int bound);
      src.set_pin(ch, lvl);
      watch(ch, exp, bound);
      clr(ch, 1'b0);
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      void'($urandom(84347));
      rstn_i = 1'b0;
      sfr_addr_i = '0;
      sfr_wr_i = 1'b0;
      sfr_wdata_i = '0;
      sfr_rd_i = 1'b0;
      latch_clr_i = '0;
      rows[0] = '{CH_ZERO, 8'h40, 2, 6, 1'b1, 1'b0};
      rows[1] = '{CH_ZERO, 8'h00, 2, 6, 1'b0, 1'b0};
      rows[2] = '{CH_FIVE, 8'h00, 2, 6, 1'b1, 1'b0};
      rows[3] = '{CH_TWO, 8'h04, 7, 24, 1'b1, 1'b0};
      rows[4] = '{CH_FOUR, 8'h10, 7, 24, 1'b1, 1'b0};
      rows[5] = '{CH_ONE, 8'h02, 63, 192, 1'b1, 1'b0};
      rows[6] = '{CH_ONE, 8'h82, 15, 48, 1'b1, 1'b1};
      repeat (20) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      check("latches at reset", 8'h00, {3'h0, request_latch_o});
      check("pin mode at reset", 8'h00, {7'h00, zero_pin_irq_mode_o});
      sfr_read(EXT_IRQ_CONTROL_ADDR, rd);
      check("control at reset", EXT_IRQ_CONTROL_RESET, rd);
      $display("test reset done");

      // four was high across reset release
      ctl(8'h30);
      repeat (50) @(negedge clk_sys_i);
      check("level before rise", 8'h00, {7'h00, request_latch_o[CH_FOUR]});
      step(CH_FOUR, 1'b0, 1'b0, 0);
      src.set_pin(CH_FOUR, 1'b1);
      watch(CH_FOUR, 1'b1, EST_TWO_CYC);
      clr(CH_FOUR, 1'b1);
      src.set_pin(CH_FOUR, 1'b0);
      repeat (30) @(negedge clk_sys_i);
      clr(CH_FOUR, 1'b0);
      $display("test level mode done");

      for (int m = 0; m < 3; m++) begin
         ctl({2'h0, 2'(m), 4'h0});
         step(CH_FOUR, 1'b1, m != 1, EST_TWO_CYC);
         step(CH_FOUR, 1'b0, m != 0, EST_TWO_CYC);
      end
      for (int e = 0; e < 2; e++) begin
         ctl({1'b1, 4'h0, e[0], e[0], 1'b0});
         step(CH_ONE, 1'b1, e == 0, EST_ONE_SHORT_CYC);
         step(CH_ONE, 1'b0, e == 1, EST_ONE_SHORT_CYC);
         step(CH_TWO, 1'b1, e == 0, EST_TWO_CYC);
         step(CH_TWO, 1'b0, e == 1, EST_TWO_CYC);
      end
      ctl(8'h02);
      step(CH_ONE, 1'b1, 1'b0, 0);
      step(CH_ONE, 1'b0, 1'b1, EST_ONE_LONG_CYC);
      $display("test edge select done");

      for (int i = 0; i < 4; i++) begin
         wd = 8'($urandom);
         sfr_write(EXT_IRQ_CONTROL_ADDR, wd);
         sfr_read(EXT_IRQ_CONTROL_ADDR, rd);
         check("control readback", wd & EXT_IRQ_CONTROL_MASK, rd);
         check("pin mode", {7'h00, wd[6]}, {7'h00, zero_pin_irq_mode_o});
         @(negedge clk_sys_i);
         check("read data idle", 8'h00, sfr_rdata_o);
      end
      sfr_write(6'h36, 8'hff);
      sfr_read(6'h36, rd);
      check("unmapped read", 8'h00, rd);
      sfr_read(EXT_IRQ_CONTROL_ADDR, rd);
      check("control kept", wd & EXT_IRQ_CONTROL_MASK, rd);
      $display("test register done");

      // idle high, falling-edge modes; quick rows wait only the switch time
      foreach (rows[r]) begin
         ctl(rows[r].ctl);
         check("pin mode", {7'h00, rows[r].ctl[6]}, {7'h00, zero_pin_irq_mode_o});
         src.set_pin(rows[r].ch, 1'b1);
         repeat (rows[r].quick ? NT_SWITCH_CYC : 300) @(negedge clk_sys_i);
         clr(rows[r].ch, 1'b0);
         src.pulse(rows[r].ch, 1'b0, 1 + $urandom % (rows[r].rej - 1));
         watch(rows[r].ch, 1'b0, 0);
         src.pulse(rows[r].ch, 1'b0, rows[r].acc + $urandom % 4);
         watch(rows[r].ch, rows[r].hit, 0);
         clr(rows[r].ch, 1'b0);
      end
      $display("test filters done");

      // mid-run reset with pin function on and four held high and armed
      ctl(8'h70);
      rstn_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      check("latches in reset", 8'h00, {3'h0, request_latch_o});
      check("pin mode in reset", 8'h00, {7'h00, zero_pin_irq_mode_o});
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      ctl(8'h30);
      repeat (50) @(negedge clk_sys_i);
      check("level after reset", 8'h00, {7'h00, request_latch_o[CH_FOUR]});
      $display("test mid-run reset done");
      test_done();
   end
endmodule
`default_nettype wire
